// ===== rtl/sbts_pkg.sv
/*
  constants and carrier types of the terminal message sequencer.
  assumes one 40 MHz system clock and a separate link clock.
*/
// Overview of operation
// (R1) addressed transmit command plus request sets window
// (R2) second request fall or final envelope clears window
// (R3) last receive data sets window, envelope clears
// (R4) envelope rise returns byte pointer to first byte
// (R5) early acknowledge clears broadcast and command flags
// (R6) middle acknowledge also clears null subaddress flag
// (R7) late acknowledge also clears null count flag
// (R8) bus controller presets counter to thirty-three
// (R9) controller done soon after thirty-third envelope
// (R10) receive command presets counter from count field
// (R11) receive done at last data sync fall
// (R12) transmit command presets commanded count plus one
// (R13) transmit done on last envelope of group
// (R14) zero count field means thirty-two words
// (R15) window low receives, high transmits, msb first
// (R16) one decrement per counted word event
// (R17) done holds until acknowledged or reset
package sbts_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned FLAG_DELAY_NS = 1500;
  localparam int unsigned FLAG_DELAY_CYC =
    (FLAG_DELAY_NS * (CLK_HZ / 1000000)) / 1000;
  localparam logic [5:0] BC_PRESET = 6'h21;
  localparam logic [5:0] FULL_COUNT = 6'h20;
  localparam int unsigned ADDR_HI = 15;
  localparam int unsigned ADDR_LO = 11;
  localparam int unsigned DIR_BIT = 10;
  localparam int unsigned SUB_HI = 9;
  localparam int unsigned SUB_LO = 5;
  localparam int unsigned CNT_HI = 4;
  localparam int unsigned CNT_LO = 0;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_TXW = 8'h08;
  localparam logic [7:0] A_RXW = 8'h0C;
  localparam logic [7:0] A_ACK = 8'h10;
  localparam int unsigned C_BC = 0;
  localparam int unsigned C_TADDR_LO = 1;
  localparam int unsigned S_WIN = 0;
  localparam int unsigned S_DONE = 1;
  localparam int unsigned S_BCAST = 2;
  localparam int unsigned S_TXI = 3;
  localparam int unsigned S_RXI = 4;
  localparam int unsigned S_NSUB = 5;
  localparam int unsigned S_NCNT = 6;
  localparam int unsigned S_PTR = 7;
  localparam int unsigned K_ZONE_LO = 0;
  localparam int unsigned K_DONE = 2;
  localparam logic [1:0] ZONE_A = 2'h0;
  localparam logic [1:0] ZONE_B = 2'h1;
  localparam logic [1:0] ZONE_C = 2'h2;
  typedef enum logic [1:0] {SBTS_IDLE, SBTS_RX, SBTS_TX, SBTS_BC} sbts_mode_t;
  typedef struct packed {
    logic cmd_sync;
    logic data_sync_pulse;
    logic send_env;
    logic transmit_request_pulse;
    logic valid_word;
  } sbts_link_t;
  typedef struct packed {
    logic [15:0] word;
    logic tgl;
    logic is_cmd;
  } sbts_word_t;
endpackage : sbts_pkg

// ===== rtl/sbts_sync.sv
/*
  three-stage synchroniser with agreement filter for link levels.
  assumes input is asynchronous to clk; output follows once stages 2 and 3 agree.
*/
`timescale 1ns/10ps
module sbts_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sbts_sync_st_t;
  sbts_sync_st_t st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.q[i] = st_ff.s3[i];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q = st_ff.q;
endmodule : sbts_sync

// ===== rtl/sbts_top.sv
/*
  terminal message sequencer: window flag, byte pointer, acknowledge zones,
  word counter, message done, apb register access.
  assumes link signals from the manchester codec on LINK_CLK; APB on CLK.
*/
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module sbts_top
  import sbts_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic LINK_CLK,
  input wire logic LINK_RST,
  input wire logic CMD_SYNC,
  input wire logic DATA_SYNC_PULSE,
  input wire logic SEND_ENV,
  input wire logic TRANSMIT_REQUEST_PULSE,
  input wire logic VALID_WORD,
  input wire logic RX_SERIAL,
  output logic TX_SERIAL,
  output logic TX_WINDOW_FLAG,
  output logic MESSAGE_DONE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  import sbts_pkg::*;

  // link-domain shifting, msb first
  typedef struct packed {
    logic [15:0] rx_sh;
    logic [4:0] rx_n;
    logic rx_cmd;
    sbts_word_t rx;
    logic [15:0] tx_sh;
    logic tx_out;
    logic env_d;
  } sbts_lnk_st_t;
  sbts_lnk_st_t l_ff, nxt_l;
  logic [15:0] tx_word_l1_ff, tx_word_l2_ff;
  logic sync_any;
  assign sync_any = CMD_SYNC | DATA_SYNC_PULSE;
  always_comb begin
    nxt_l = l_ff;
    nxt_l.env_d = SEND_ENV;
    if (sync_any) begin
      nxt_l.rx_sh = {l_ff.rx_sh[14:0], RX_SERIAL}; // R15
      nxt_l.rx_n = l_ff.rx_n + 5'h01;
      nxt_l.rx_cmd = CMD_SYNC;
    end else begin
      nxt_l.rx_n = 5'h00;
      if (l_ff.rx_n != 5'h00) begin
        nxt_l.rx.word = l_ff.rx_sh;
        nxt_l.rx.is_cmd = l_ff.rx_cmd;
        nxt_l.rx.tgl = ~l_ff.rx.tgl;
      end
    end
    if (!SEND_ENV) begin
      nxt_l.tx_sh = tx_word_l2_ff;
    end else begin
      nxt_l.tx_out = l_ff.tx_sh[15]; // R15
      nxt_l.tx_sh = {l_ff.tx_sh[14:0], 1'b0};
    end
  end
  always_ff @(posedge LINK_CLK) begin
    if (LINK_RST) begin
      l_ff <= '0;
    end else begin
      l_ff <= nxt_l;
    end
  end
  assign TX_SERIAL = l_ff.tx_out;

  // link levels and word toggle into CLK domain
  sbts_link_t lk;
  logic w_tgl;
  sbts_sync #(.W(6)) u_sync (
    .clk(CLK),
    .rst(RST),
    .d({CMD_SYNC, DATA_SYNC_PULSE, SEND_ENV, TRANSMIT_REQUEST_PULSE,
        VALID_WORD, l_ff.rx.tgl}),
    .q({lk, w_tgl})
  );

  typedef struct packed {
    sbts_link_t lk_d;
    logic tgl_d;
    logic [15:0] rxw;
    logic rxw_cmd;
    logic win;
    logic [1:0] req_falls;
    logic ptr_second;
    logic [15:0] txw;
    logic [5:0] cnt;
    sbts_mode_t mode;
    logic done;
    logic bcast;
    logic txi;
    logic rxi;
    logic nsub;
    logic ncnt;
    logic [1:0] zone;
    logic bc;
    logic [4:0] taddr;
    logic [31:0] prdata;
  } sbts_st_t;
  sbts_st_t s_ff, nxt_s;

  // zero field means thirty-two
  function automatic logic [5:0] word_count(input logic [4:0] f);
    word_count = (f == 5'h00) ? FULL_COUNT : {1'b0, f}; // R14
  endfunction : word_count

  logic ds_fall, env_rise, env_fall, req_fall, word_new, ours, acc;
  logic cmd_hit, bc_hit;
  logic [15:0] cw;
  assign ds_fall = s_ff.lk_d.data_sync_pulse & ~lk.data_sync_pulse;
  assign env_rise = ~s_ff.lk_d.send_env & lk.send_env;
  assign env_fall = s_ff.lk_d.send_env & ~lk.send_env;
  assign req_fall = s_ff.lk_d.transmit_request_pulse &
                    ~lk.transmit_request_pulse;
  assign word_new = w_tgl ^ s_ff.tgl_d;
  assign cw = l_ff.rx.word;
  assign ours = cw[ADDR_HI:ADDR_LO] == s_ff.taddr;
  assign acc = PSEL & PENABLE;
  // flag set by an arriving word wins over a clearing acknowledge
  assign cmd_hit = word_new & l_ff.rx.is_cmd & ~s_ff.bc & ours;
  assign bc_hit = word_new & l_ff.rx.is_cmd &
                  (cw[ADDR_HI:ADDR_LO] == 5'h1F);
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.lk_d = lk;
    nxt_s.tgl_d = w_tgl;
    // acknowledge zone tracks phase of word reception
    if (!lk.cmd_sync && !lk.data_sync_pulse) begin
      nxt_s.zone = ZONE_A;
    end else if (s_ff.zone == ZONE_A) begin
      nxt_s.zone = ZONE_B;
    end else begin
      nxt_s.zone = ZONE_C;
    end
    // decoded word arrival (held stable in link domain)
    if (word_new) begin
      nxt_s.rxw = cw;
      nxt_s.rxw_cmd = l_ff.rx.is_cmd;
      if (l_ff.rx.is_cmd && !s_ff.bc && ours) begin
        nxt_s.nsub = cw[SUB_HI:SUB_LO] == 5'h00;
        nxt_s.ncnt = cw[CNT_HI:CNT_LO] == 5'h00;
        nxt_s.req_falls = 2'h0;
        if (cw[DIR_BIT]) begin
          nxt_s.txi = 1'b1;
          nxt_s.mode = SBTS_TX;
          nxt_s.cnt = word_count(cw[CNT_HI:CNT_LO]) + 6'h01; // R12
        end else begin
          nxt_s.rxi = 1'b1;
          nxt_s.mode = SBTS_RX;
          nxt_s.cnt = word_count(cw[CNT_HI:CNT_LO]); // R10
        end
      end
      if (l_ff.rx.is_cmd && cw[ADDR_HI:ADDR_LO] == 5'h1F) begin
        nxt_s.bcast = 1'b1;
      end
    end
    // transmit request: controller always, terminal when addressed
    if (lk.transmit_request_pulse && !s_ff.lk_d.transmit_request_pulse) begin
      if (s_ff.bc || (s_ff.mode == SBTS_TX && s_ff.rxw_cmd &&
          s_ff.rxw[DIR_BIT])) begin
        nxt_s.win = 1'b1; // R1
      end
    end
    if (req_fall && s_ff.mode == SBTS_TX) begin
      nxt_s.req_falls = s_ff.req_falls + 2'h1;
      if (s_ff.req_falls == 2'h1) begin
        nxt_s.win = 1'b0; // R2
      end
    end
    // word counting
    if (s_ff.mode == SBTS_RX && ds_fall && s_ff.cnt != 6'h00) begin
      nxt_s.cnt = s_ff.cnt - 6'h01; // R16
      if (s_ff.cnt == 6'h01) begin
        nxt_s.done = 1'b1; // R11
        nxt_s.win = 1'b1; // R3
        nxt_s.mode = SBTS_IDLE;
      end
    end
    if ((s_ff.mode == SBTS_TX || s_ff.mode == SBTS_BC) && env_rise &&
        s_ff.cnt != 6'h00) begin
      nxt_s.cnt = s_ff.cnt - 6'h01; // R16
      if (s_ff.cnt == 6'h01) begin
        nxt_s.done = 1'b1; // R9 R13
        nxt_s.win = 1'b0; // R2
        nxt_s.mode = SBTS_IDLE;
      end
    end
    if (env_rise) begin
      nxt_s.ptr_second = 1'b0; // R4
      if (s_ff.mode == SBTS_IDLE && !s_ff.bc) begin
        nxt_s.win = 1'b0; // R3
      end
    end
    // apb access
    nxt_s.prdata = 32'h0;
    if (acc && PWRITE) begin
      unique case (PADDR)
        A_CTRL: begin
          nxt_s.bc = PWDATA[C_BC];
          nxt_s.taddr = PWDATA[C_TADDR_LO +: 5];
          if (PWDATA[C_BC]) begin
            nxt_s.mode = SBTS_BC;
            nxt_s.cnt = BC_PRESET; // R8
          end
        end
        A_TXW: begin
          if (!s_ff.ptr_second) begin
            nxt_s.txw[15:8] = PWDATA[7:0]; // R4
          end else begin
            nxt_s.txw[7:0] = PWDATA[7:0];
          end
          nxt_s.ptr_second = ~s_ff.ptr_second;
        end
        A_ACK: begin
          if (PWDATA[K_DONE] && !(nxt_s.done && !s_ff.done)) begin
            nxt_s.done = 1'b0; // R17
          end
          if (!bc_hit) begin
            nxt_s.bcast = 1'b0; // R5
          end
          if (!cmd_hit) begin
            nxt_s.txi = 1'b0; // R5
            nxt_s.rxi = 1'b0; // R5
            if (s_ff.zone != ZONE_A) begin
              nxt_s.nsub = 1'b0; // R6
            end
            if (s_ff.zone == ZONE_C) begin
              nxt_s.ncnt = 1'b0; // R7
            end
          end
        end
        default: begin
        end
      endcase
      if (env_rise) begin
        nxt_s.ptr_second = 1'b0; // R4
      end
    end else if (acc) begin
      unique case (PADDR)
        A_CTRL: nxt_s.prdata = {26'h0, s_ff.taddr, s_ff.bc};
        A_STAT: begin
          nxt_s.prdata[S_WIN] = s_ff.win;
          nxt_s.prdata[S_DONE] = s_ff.done;
          nxt_s.prdata[S_BCAST] = s_ff.bcast;
          nxt_s.prdata[S_TXI] = s_ff.txi;
          nxt_s.prdata[S_RXI] = s_ff.rxi;
          nxt_s.prdata[S_NSUB] = s_ff.nsub;
          nxt_s.prdata[S_NCNT] = s_ff.ncnt;
          nxt_s.prdata[S_PTR] = s_ff.ptr_second;
        end
        A_TXW: nxt_s.prdata = {16'h0, s_ff.txw};
        A_RXW: nxt_s.prdata = {16'h0, s_ff.rxw};
        default: nxt_s.prdata = 32'h0;
      endcase
    end else begin
      nxt_s.prdata = s_ff.prdata;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // tx word crosses to link domain; stable while envelope high
  always_ff @(posedge LINK_CLK) begin
    if (LINK_RST) begin
      tx_word_l1_ff <= 16'h0000;
      tx_word_l2_ff <= 16'h0000;
    end else begin
      tx_word_l1_ff <= s_ff.txw;
      tx_word_l2_ff <= tx_word_l1_ff;
    end
  end

  // read data: combinational from current register state for same-cycle answer
  always_comb begin
    PRDATA = 32'h0;
    if (acc && !PWRITE) begin
      unique case (PADDR)
        A_CTRL: PRDATA = {26'h0, s_ff.taddr, s_ff.bc};
        A_STAT: PRDATA = {24'h0, s_ff.ptr_second, s_ff.ncnt, s_ff.nsub,
                          s_ff.rxi, s_ff.txi, s_ff.bcast, s_ff.done,
                          s_ff.win};
        A_TXW: PRDATA = {16'h0, s_ff.txw};
        A_RXW: PRDATA = {16'h0, s_ff.rxw};
        default: PRDATA = 32'h0;
      endcase
    end
  end
  assign TX_WINDOW_FLAG = s_ff.win;
  assign MESSAGE_DONE = s_ff.done;

  sequence env_up_s;
    !s_ff.lk_d.send_env ##0 lk.send_env;
  endsequence
  AST_PTR_RESET: assert property (@(posedge CLK) disable iff (RST)
    env_up_s |=> !s_ff.ptr_second) // R4
    else $error("byte pointer not reset by envelope");
  AST_BC_PRESET: assert property (@(posedge CLK) disable iff (RST)
    acc && PWRITE && PADDR == A_CTRL && PWDATA[C_BC]
    |=> s_ff.cnt == BC_PRESET) // R8
    else $error("controller preset wrong");
  AST_DONE_HOLD: assert property (@(posedge CLK) disable iff (RST)
    s_ff.done && !(acc && PWRITE && PADDR == A_ACK) |=> s_ff.done) // R17
    else $error("done dropped without acknowledge");
  AST_ACK_A: assert property (@(posedge CLK) disable iff (RST)
    acc && PWRITE && PADDR == A_ACK && s_ff.zone == ZONE_A && s_ff.nsub
    && !word_new |=> s_ff.nsub && !s_ff.txi && !s_ff.rxi) // R5
    else $error("zone a acknowledge wrong");
  AST_ACK_B: assert property (@(posedge CLK) disable iff (RST)
    acc && PWRITE && PADDR == A_ACK && s_ff.zone == ZONE_B && !word_new
    |=> !s_ff.nsub && !s_ff.bcast) // R6
    else $error("zone b acknowledge wrong");
  AST_ACK_C: assert property (@(posedge CLK) disable iff (RST)
    acc && PWRITE && PADDR == A_ACK && s_ff.zone == ZONE_C && !word_new
    |=> !s_ff.ncnt && !s_ff.nsub) // R7
    else $error("zone c acknowledge wrong");
  AST_RX_DONE: assert property (@(posedge CLK) disable iff (RST)
    s_ff.mode == SBTS_RX && ds_fall && s_ff.cnt == 6'h01
    |=> s_ff.done && s_ff.win) // R11
    else $error("receive completion missed");
  AST_TX_DONE: assert property (@(posedge CLK) disable iff (RST)
    s_ff.mode == SBTS_TX && env_rise && s_ff.cnt == 6'h01
    |=> s_ff.done && !s_ff.win) // R13
    else $error("transmit completion missed");
  AST_TX_WIN: assert property (@(posedge CLK) disable iff (RST)
    s_ff.mode == SBTS_TX && s_ff.rxw_cmd && s_ff.rxw[DIR_BIT] &&
    lk.transmit_request_pulse && !s_ff.lk_d.transmit_request_pulse &&
    !env_rise && !req_fall |=> s_ff.win) // R1
    else $error("transmit request did not open window");
endmodule : sbts_top

// ===== verification/sbts_codec.sv
/*
  behavioural manchester codec model at the link side of the sequencer.
  assumes the bench calls one of its tasks at a time.
*/
`timescale 1ns/10ps
module sbts_codec (
  output logic link_clk,
  output sbts_pkg::sbts_link_t lnk,
  output logic rx_serial
);
  import sbts_pkg::*;
  // receive clock runs free: idle line timing counts it
  initial begin
    link_clk = 1'h0;
    lnk = '0;
    rx_serial = 1'h0;
    #7;
    forever #62.5 link_clk = ~link_clk;
  end
  task automatic word(input logic [15:0] w, input logic cmd);
    for (int i = 15; i >= 0; i--) begin
      @(posedge link_clk);
      lnk.cmd_sync <= cmd;
      lnk.data_sync_pulse <= ~cmd;
      rx_serial <= w[i];
    end
    @(posedge link_clk);
    lnk.cmd_sync <= 1'h0;
    lnk.data_sync_pulse <= 1'h0;
    lnk.valid_word <= 1'h1;
    rx_serial <= ~w[0];
    @(posedge link_clk);
    lnk.valid_word <= 1'h0;
  endtask : word
  task automatic envelope();
    @(posedge link_clk);
    lnk.send_env <= 1'h1;
    repeat (16) @(posedge link_clk);
    lnk.send_env <= 1'h0;
    @(posedge link_clk);
  endtask : envelope
  task automatic request();
    @(posedge link_clk);
    lnk.transmit_request_pulse <= 1'h1;
    repeat (2) @(posedge link_clk);
    lnk.transmit_request_pulse <= 1'h0;
    @(posedge link_clk);
  endtask : request
endmodule : sbts_codec

// ===== verification/tb_top.sv
/*
  self-checking bench of the terminal message sequencer.
  assumes the codec model drives the link pins; apb master lives here.
*/
`timescale 1ns/10ps
module tb_top;
  import sbts_pkg::*;
  localparam logic [31:0] M_WIN = 32'h1 << S_WIN;
  localparam logic [31:0] M_DONE = 32'h1 << S_DONE;
  localparam logic [31:0] M_CAST = 32'h1 << S_BCAST;
  localparam logic [31:0] M_TXI = 32'h1 << S_TXI;
  localparam logic [31:0] M_RXI = 32'h1 << S_RXI;
  localparam logic [31:0] M_NSUB = 32'h1 << S_NSUB;
  localparam logic [31:0] M_NCNT = 32'h1 << S_NCNT;
  localparam logic [31:0] M_PTR = 32'h1 << S_PTR;
  logic clk, rst, link_rst, link_clk, rx_serial, tx_serial, win, done;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  sbts_link_t lnk;
  int mismatches = 0;
  int n_checks = 0;
  sbts_codec i_codec (.link_clk(link_clk), .lnk(lnk), .rx_serial(rx_serial));
  sbts_top i_dut (
    .CLK(clk), .RST(rst), .LINK_CLK(link_clk), .LINK_RST(link_rst),
    .CMD_SYNC(lnk.cmd_sync), .DATA_SYNC_PULSE(lnk.data_sync_pulse),
    .SEND_ENV(lnk.send_env),
    .TRANSMIT_REQUEST_PULSE(lnk.transmit_request_pulse),
    .VALID_WORD(lnk.valid_word), .RX_SERIAL(rx_serial),
    .TX_SERIAL(tx_serial), .TX_WINDOW_FLAG(win), .MESSAGE_DONE(done),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr)
  );
  always #12.5 clk = ~clk;
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) mismatches++;
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'h1, a, d, q);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    apb(1'h0, a, 32'h0, q);
    chk(nm, e, q & m);
  endtask : rd_chk
  task automatic st(input string nm, input logic [31:0] m,
                    input logic [31:0] e);
    rd_chk(nm, A_STAT, m, e);
  endtask : st
  task automatic settle();
    repeat (10) @(posedge clk);
  endtask : settle
  task automatic t_reset();
    st("stat reset", 32'hFFFFFFFF, 32'h0);
    chk("pins reset", 32'h0, {29'h0, win, done, tx_serial});
    wr(8'h14, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'h14, 32'hFFFFFFFF, 32'h0);
  endtask : t_reset
  task automatic t_tx();
    logic [15:0] sh;
    sh = 16'h0000;
    wr(A_CTRL, 32'h0000000A);
    i_codec.word(16'h2C62, 1'h1);
    i_codec.request();
    settle();
    st("window set", M_WIN, M_WIN);
    chk("window pin", 32'h1, {31'h0, win});
    wr(A_TXW, 32'h000000A5);
    st("pointer moved", M_PTR, M_PTR);
    settle();
    fork
      i_codec.envelope();
      begin
        @(posedge lnk.send_env);
        repeat (16) begin
          @(posedge link_clk);
          @(negedge link_clk);
          sh = {sh[14:0], tx_serial};
        end
      end
    join
    chk("serial out", 32'h0000A500, {16'h0, sh});
    i_codec.envelope();
    settle();
    st("plus one", M_WIN | M_DONE | M_PTR, M_WIN);
    i_codec.envelope();
    settle();
    st("tx done", M_WIN | M_DONE, M_DONE);
    wr(A_ACK, 32'h00000004);
    i_codec.word(16'h2C62, 1'h1);
    i_codec.request();
    settle();
    st("window again", M_WIN, M_WIN);
    i_codec.request();
    settle();
    st("second fall", M_WIN, 32'h0);
  endtask : t_tx
  task automatic t_rx();
    i_codec.word(16'h2800, 1'h1);
    settle();
    rd_chk("rx word", A_RXW, 32'h0000FFFF, 32'h00002800);
    st("cmd flags", M_RXI | M_NSUB | M_NCNT, M_RXI | M_NSUB | M_NCNT);
    wr(A_ACK, 32'h0);
    st("early ack", M_CAST | M_TXI | M_RXI | M_NSUB | M_NCNT,
       M_NSUB | M_NCNT);
    fork
      i_codec.word(16'h1234, 1'h0);
      begin
        repeat (40) @(posedge clk);
        wr(A_ACK, 32'h0);
      end
    join
    settle();
    st("late ack", M_NSUB | M_NCNT, 32'h0);
    for (int i = 1; i < 31; i++) i_codec.word(16'(i), 1'h0);
    settle();
    st("31 of 32", M_DONE | M_WIN, 32'h0);
    i_codec.word(16'h00FF, 1'h0);
    settle();
    st("rx done", M_DONE | M_WIN, M_DONE | M_WIN);
    i_codec.envelope();
    settle();
    st("env clears", M_DONE | M_WIN, M_DONE);
    wr(A_ACK, 32'h00000004);
    chk("done acked", 32'h0, {31'h0, done});
  endtask : t_rx
  task automatic t_bc();
    wr(A_CTRL, 32'h0000000B);
    repeat (32) i_codec.envelope();
    settle();
    st("bc 32", M_DONE, 32'h0);
    fork
      i_codec.envelope();
      begin
        @(posedge lnk.send_env);
        repeat (FLAG_DELAY_CYC) @(posedge clk);
        chk("bc done", 32'h1, {31'h0, done});
      end
    join
  endtask : t_bc
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    close_out();
  end
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    link_rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (16) @(posedge clk);
    link_rst <= 1'h0;
    settle();
    t_reset();
    t_tx();
    t_rx();
    t_bc();
    close_out();
  end
endmodule : tb_top
